// >>> hdl/pmw_defs.svh
`ifndef PMW_DEFS_SVH
`define PMW_DEFS_SVH

// ----------------------------------------------------------------------
// Register indices on the device link.
// ----------------------------------------------------------------------
`define PMW_ADDR_W 4
`define PMW_REG_PWRCTL 4'h0
`define PMW_REG_INTSTS 4'h1
`define PMW_REG_INTEN 4'h2
`define PMW_REG_PROBE 4'h3
`define PMW_REG_PHYMODE 4'h4

// ----------------------------------------------------------------------
// Field positions.
// ----------------------------------------------------------------------
`define PMW_READY_BIT 0
`define PMW_SEL_LO 1
`define PMW_SEL_HI 2
`define PMW_WAKE_SOURCE_STATUS_LO 4
`define PMW_WAKE_SOURCE_STATUS_HI 5
`define PMW_PINEN_BIT 8
`define PMW_PULSE_BIT 9
`define PMW_WOLEN_BIT 10
`define PMW_EDEN_BIT 11
`define PMW_PMEINT_BIT 0
`define PMW_EDPD_BIT 13

// ----------------------------------------------------------------------
// Field codes and reset values.
// ----------------------------------------------------------------------
`define PMW_SEL_NORMAL 2'h0
`define PMW_SEL_FRAME 2'h1
`define PMW_SEL_ENERGY 2'h2
`define PMW_WAKE_SOURCE_STATUS_NONE 2'h0
`define PMW_WAKE_SOURCE_STATUS_ENERGY 2'h1
`define PMW_WAKE_SOURCE_STATUS_FRAME 2'h2
`define PMW_CTRL_RESET 32'h0000_0001
`define PMW_READY_RESET 1'b1

// ----------------------------------------------------------------------
// Timing.
// ----------------------------------------------------------------------
`define PMW_CLK_MHZ 125
`define PMW_READY_MS 2
`define PMW_PULSE_MS 50
`define PMW_READY_CYC (`PMW_READY_MS * 1000 * `PMW_CLK_MHZ)
`define PMW_PULSE_CYC (`PMW_PULSE_MS * 1000 * `PMW_CLK_MHZ)

// ----------------------------------------------------------------------
// Host controller register byte offsets on the AHB-Lite side.
// ----------------------------------------------------------------------
`define PMW_H_TARGET 8'h00
`define PMW_H_WDATA 8'h04
`define PMW_H_GO 8'h08
`define PMW_H_STATUS 8'h0c
`define PMW_H_RDATA 8'h10
`define PMW_H_WRITE_BIT 8
`define PMW_H_BUSY_BIT 0
`define PMW_H_WAKE_BIT 1
`define PMW_H_IRQ_BIT 2

`endif

// >>> hdl/pmw_pkg.sv
package pmw_pkg;
   typedef enum logic [3:0] {
      PMW_NORMAL = 4'b0001,
      PMW_FRAME_SLEEP = 4'b0010,
      PMW_ENERGY_SLEEP = 4'b0100,
      PMW_WAKING = 4'b1000
   } pmw_state_type;

   typedef enum logic [1:0] {
      PMW_H_IDLE = 2'b01,
      PMW_H_WAIT = 2'b10
   } pmw_host_state_type;

   // Write-one-to-clear with a set that wins over the clear.
   function automatic logic pmw_sticky(input logic cur, input logic set,
                                       input logic clr);
      pmw_sticky = set | (cur & ~clr);
   endfunction
endpackage

// >>> hdl/pmw_if.sv
`timescale 1ns/1ps
`include "pmw_defs.svh"

interface pmw_if;
   logic reqValid;
   logic reqWrite;
   logic [`PMW_ADDR_W-1:0] reqAddr;
   logic [31:0] reqWdata;
   logic ackValid;
   logic [31:0] ackRdata;
   logic wakePin;
   logic hostIrq;

   modport dev(input reqValid, input reqWrite, input reqAddr,
               input reqWdata, output ackValid, output ackRdata,
               output wakePin, output hostIrq);
   modport host(output reqValid, output reqWrite, output reqAddr,
                output reqWdata, input ackValid, input ackRdata,
                input wakePin, input hostIrq);
endinterface

// >>> hdl/pmw_device.sv
`timescale 1ns/1ps
`include "pmw_defs.svh"

// What this block does
// - Select 01 enters frame-wake sleep state
// - Host sets powerdown bit, then selects 10
// - Entering sleep clears the ready flag
// - Host only reads power control while unready
// - Probe write wakes and resets selection field
// - Writes honoured only after a first read
// - Frame sleep detects frames, drives wake pin
// - Frame detection sets wake source to 10
// - Energy sleep carrier sets source 01, pin
// - Carrier already present reports at once
// - Wake event sets interrupt status, raises irq
// - Interrupt bit clears only after event ends
// - Pulse select gives 50ms pulse, else level
// - Wake pin drops with source, enables cleared
// - Wake source status is host readable
// - Energy sleep gates internal and MAC clocks
// - Registers keep contents across sleep states
// - Host clears powerdown bit after ready
// - Host programs filters before frame sleep
// - Host clears wake source after ready
// - Ready flag set within 2ms of wake
// - Powerdown bit enables energy-detect powerdown
module pmw_device
   import pmw_pkg::*;
#(
   parameter int READY_CYC = `PMW_READY_CYC,
   parameter int PULSE_CYC = `PMW_PULSE_CYC
) (
   // Clock and reset.
   input wire logic clk_sys,
   input wire logic rst_n,
   // Link to the host.
   pmw_if.dev link,
   // Detector inputs from outside the clock domain.
   input wire logic frameDetect,
   input wire logic lineEnergy,
   // Clock gates and PHY control.
   output logic clkEnMacHost,
   output logic clkEnRxPm,
   output logic clkEnInternal,
   output logic phyEnergyPowerdown
);
   // -------------------------------------------------------------------
   // Input synchronisers.
   // -------------------------------------------------------------------
   logic [1:0] syncA_q;
   logic [1:0] syncB_q;
   logic [1:0] syncC_q;
   logic [1:0] detect_q;

   always_ff @(posedge clk_sys) begin
      syncA_q <= {lineEnergy, frameDetect};
      syncB_q <= syncA_q;
      syncC_q <= syncB_q;
   end

   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         detect_q <= 2'h0;
      end else begin
         for (int i = 0; i < 2; i++) begin
            if (syncB_q[i] == syncC_q[i]) begin
               detect_q[i] <= syncC_q[i];
            end
         end
      end
   end

   // -------------------------------------------------------------------
   // State and registers.
   // -------------------------------------------------------------------
   pmw_state_type state_q;
   pmw_state_type state_d;
   logic ready_q;
   logic readSeen_q;
   logic [1:0] sel_q;
   logic [1:0] wake_source_status_q;
   logic pinEn_q;
   logic pulseSel_q;
   logic wolEn_q;
   logic edEn_q;
   logic pmeInt_q;
   logic pmeIntEn_q;
   logic edpd_q;
   logic [31:0] waitCnt_q;
   logic [31:0] pulseCnt_q;
   logic wakeEvent_q;
   logic ackValid_q;
   logic [31:0] ackRdata_q;
   logic wakePin_q;
   logic hostIrq_q;

   // -------------------------------------------------------------------
   // Request decode.
   // -------------------------------------------------------------------
   wire asleep = (state_q == PMW_FRAME_SLEEP) ||
                 (state_q == PMW_ENERGY_SLEEP);
   wire rdReq = link.reqValid & ~link.reqWrite;
   wire wrReq = link.reqValid & link.reqWrite;
   wire hitCtl = (link.reqAddr == `PMW_REG_PWRCTL);
   wire hitSts = (link.reqAddr == `PMW_REG_INTSTS);
   wire hitEn = (link.reqAddr == `PMW_REG_INTEN);
   wire hitProbe = (link.reqAddr == `PMW_REG_PROBE);
   wire hitPhy = (link.reqAddr == `PMW_REG_PHYMODE);
   // Writes count only once awake, ready and after a first read.
   wire wrOk = wrReq & ready_q & readSeen_q & (state_q == PMW_NORMAL);
   wire wrCtl = wrOk & hitCtl;
   wire wakeWrite = wrReq & hitProbe & asleep;
   wire [1:0] newSel = link.reqWdata[`PMW_SEL_HI:`PMW_SEL_LO];
   wire [1:0] wupsClr = wrCtl ?
        link.reqWdata[`PMW_WAKE_SOURCE_STATUS_HI:`PMW_WAKE_SOURCE_STATUS_LO] : 2'h0;
   wire frameHit = (state_q == PMW_FRAME_SLEEP) & detect_q[0];
   // A level test also catches carrier present at entry.
   wire energyHit = (state_q == PMW_ENERGY_SLEEP) & detect_q[1];
   wire [1:0] wupsSet = {frameHit, energyHit};
   wire wakeEvent = (wake_source_status_q[1] & wolEn_q) | (wake_source_status_q[0] & edEn_q);
   wire wakeRise = wakeEvent & ~wakeEvent_q;
   wire pulseRun = (pulseCnt_q != 32'h0);
   // Pin follows the event and its enables; pulse mode adds a timer.
   wire pinNext = wakeEvent & pinEn_q &
                  (~pulseSel_q | pulseRun | wakeRise);
   wire readOk = ~asleep & (state_q != PMW_WAKING) | hitCtl;
   wire [31:0] ctlWord = {20'h0, edEn_q, wolEn_q, pulseSel_q, pinEn_q,
                          2'h0, wake_source_status_q, 1'b0, sel_q, ready_q};
   wire [31:0] rdMux =
        !readOk ? 32'h0 :
        hitCtl ? ctlWord :
        hitSts ? {31'h0, pmeInt_q} :
        hitEn ? {31'h0, pmeIntEn_q} :
        hitPhy ? {18'h0, edpd_q, 13'h0} : 32'h0;

   // -------------------------------------------------------------------
   // Power state machine.
   // -------------------------------------------------------------------
   always_comb begin
      state_d = state_q;
      case (state_q)
         PMW_NORMAL: begin
            if (wrCtl && newSel == `PMW_SEL_FRAME) begin
               state_d = PMW_FRAME_SLEEP;
            end else if (wrCtl && newSel == `PMW_SEL_ENERGY) begin
               state_d = PMW_ENERGY_SLEEP;
            end
         end
         PMW_FRAME_SLEEP, PMW_ENERGY_SLEEP: begin
            if (wakeWrite) begin
               state_d = PMW_WAKING;
            end
         end
         PMW_WAKING: begin
            if (waitCnt_q >= 32'(READY_CYC - 1)) begin
               state_d = PMW_NORMAL;
            end
         end
         default: state_d = PMW_NORMAL;
      endcase
   end

   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         state_q <= PMW_NORMAL;
         waitCnt_q <= 32'h0;
      end else begin
         state_q <= state_d;
         waitCnt_q <= (state_q == PMW_WAKING) ? waitCnt_q + 32'h1 : 32'h0;
      end
   end

   // Ready drops on sleep entry and returns after the wake wait.
   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         ready_q <= `PMW_READY_RESET;
         readSeen_q <= 1'b0;
         sel_q <= `PMW_SEL_NORMAL;
      end else begin
         if (state_d != PMW_NORMAL) begin
            ready_q <= 1'b0;
         end else if (state_q == PMW_WAKING) begin
            ready_q <= 1'b1;
         end
         if (state_q == PMW_WAKING) begin
            readSeen_q <= 1'b0;
         end else if (rdReq && readOk) begin
            readSeen_q <= 1'b1;
         end
         if (wakeWrite) begin
            sel_q <= `PMW_SEL_NORMAL;
         end else if (wrCtl) begin
            sel_q <= newSel;
         end
      end
   end

   // -------------------------------------------------------------------
   // Configuration and status; untouched by sleep.
   // -------------------------------------------------------------------
   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         pinEn_q <= 1'b0;
         pulseSel_q <= 1'b0;
         wolEn_q <= 1'b0;
         edEn_q <= 1'b0;
         pmeIntEn_q <= 1'b0;
         edpd_q <= 1'b0;
      end else begin
         if (wrCtl) begin
            pinEn_q <= link.reqWdata[`PMW_PINEN_BIT];
            pulseSel_q <= link.reqWdata[`PMW_PULSE_BIT];
            wolEn_q <= link.reqWdata[`PMW_WOLEN_BIT];
            edEn_q <= link.reqWdata[`PMW_EDEN_BIT];
         end
         if (wrOk && hitEn) begin
            pmeIntEn_q <= link.reqWdata[`PMW_PMEINT_BIT];
         end
         if (wrOk && hitPhy) begin
            edpd_q <= link.reqWdata[`PMW_EDPD_BIT];
         end
      end
   end

   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         wake_source_status_q <= `PMW_WAKE_SOURCE_STATUS_NONE;
         pmeInt_q <= 1'b0;
         wakeEvent_q <= 1'b0;
         pulseCnt_q <= 32'h0;
      end else begin
         for (int i = 0; i < 2; i++) begin
            wake_source_status_q[i] <= pmw_sticky(wake_source_status_q[i], wupsSet[i], wupsClr[i]);
         end
         // Clearing only works once the event has ended.
         pmeInt_q <= pmw_sticky(pmeInt_q, wakeEvent,
                     wrOk & hitSts & link.reqWdata[`PMW_PMEINT_BIT]);
         wakeEvent_q <= wakeEvent;
         if (wakeRise) begin
            pulseCnt_q <= 32'(PULSE_CYC - 1);
         end else if (pulseRun) begin
            pulseCnt_q <= pulseCnt_q - 32'h1;
         end
      end
   end

   // -------------------------------------------------------------------
   // Outputs.
   // -------------------------------------------------------------------
   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         ackValid_q <= 1'b0;
         ackRdata_q <= 32'h0;
         wakePin_q <= 1'b0;
         hostIrq_q <= 1'b0;
         clkEnMacHost <= 1'b1;
         clkEnRxPm <= 1'b1;
         clkEnInternal <= 1'b1;
         phyEnergyPowerdown <= 1'b0;
      end else begin
         ackValid_q <= link.reqValid;
         ackRdata_q <= rdReq ? rdMux : 32'h0;
         wakePin_q <= pinNext;
         hostIrq_q <= pmeInt_q & pmeIntEn_q;
         clkEnMacHost <= ~asleep;
         clkEnRxPm <= (state_q != PMW_ENERGY_SLEEP);
         clkEnInternal <= (state_q != PMW_ENERGY_SLEEP);
         phyEnergyPowerdown <= edpd_q;
      end
   end

   assign link.ackValid = ackValid_q;
   assign link.ackRdata = ackRdata_q;
   assign link.wakePin = wakePin_q;
   assign link.hostIrq = hostIrq_q;
endmodule

// >>> hdl/pmw_host.sv
`timescale 1ns/1ps
`include "pmw_defs.svh"

module pmw_host
   import pmw_pkg::*;
(
   // Clock and reset.
   input wire logic clk_sys,
   input wire logic rst_n,
   // Link to the device.
   pmw_if.host link,
   // AHB-Lite slave.
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic [31:0] hrdata,
   output logic hreadyout,
   output logic hresp
);
   // -------------------------------------------------------------------
   // AHB-Lite address and data phases.
   // -------------------------------------------------------------------
   logic wrPend_q;
   logic [7:0] wrAddr_q;
   logic [8:0] target_q;
   logic [31:0] wdata_q;
   logic [31:0] rdata_q;
   logic busy_q;
   pmw_host_state_type hstate_q;
   logic reqValid_q;

   wire addrPhase = hsel & htrans[1] & hready;
   wire [7:0] aOff = haddr[7:0];
   wire [31:0] status = {29'h0, link.hostIrq, link.wakePin, busy_q};
   wire [31:0] rdMux =
        (aOff == `PMW_H_TARGET) ? {23'h0, target_q} :
        (aOff == `PMW_H_WDATA) ? wdata_q :
        (aOff == `PMW_H_STATUS) ? status :
        (aOff == `PMW_H_RDATA) ? rdata_q : 32'h0;
   // A new command is taken only while the link is idle.
   wire goWrite = wrPend_q & (wrAddr_q == `PMW_H_GO) & ~busy_q;

   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         wrPend_q <= 1'b0;
         wrAddr_q <= 8'h0;
         hrdata <= 32'h0;
         hreadyout <= 1'b1;
         hresp <= 1'b0;
      end else begin
         wrPend_q <= addrPhase & hwrite;
         wrAddr_q <= haddr[7:0];
         if (addrPhase && !hwrite) begin
            hrdata <= rdMux;
         end
      end
   end

   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         target_q <= 9'h0;
         wdata_q <= 32'h0;
      end else if (wrPend_q && wrAddr_q == `PMW_H_TARGET) begin
         target_q <= hwdata[8:0];
      end else if (wrPend_q && wrAddr_q == `PMW_H_WDATA) begin
         wdata_q <= hwdata;
      end
   end

   // -------------------------------------------------------------------
   // Link sequencer: one request, then wait for its answer.
   // -------------------------------------------------------------------
   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         hstate_q <= PMW_H_IDLE;
         reqValid_q <= 1'b0;
         busy_q <= 1'b0;
         rdata_q <= 32'h0;
      end else begin
         reqValid_q <= 1'b0;
         case (hstate_q)
            PMW_H_IDLE: begin
               if (goWrite) begin
                  reqValid_q <= 1'b1;
                  busy_q <= 1'b1;
                  hstate_q <= PMW_H_WAIT;
               end
            end
            PMW_H_WAIT: begin
               if (link.ackValid) begin
                  rdata_q <= link.ackRdata;
                  busy_q <= 1'b0;
                  hstate_q <= PMW_H_IDLE;
               end
            end
            default: hstate_q <= PMW_H_IDLE;
         endcase
      end
   end

   assign link.reqValid = reqValid_q;
   assign link.reqWrite = target_q[`PMW_H_WRITE_BIT];
   assign link.reqAddr = target_q[`PMW_ADDR_W-1:0];
   assign link.reqWdata = wdata_q;
endmodule

// >>> verification/pmw_props.sv
`timescale 1ns/1ps
`include "pmw_defs.svh"

module pmw_props (
   // Clock and reset.
   input wire logic clk_sys,
   input wire logic rst_n,
   // Device link.
   input wire logic reqValid,
   input wire logic reqWrite,
   input wire logic [`PMW_ADDR_W-1:0] reqAddr,
   input wire logic [31:0] reqWdata,
   input wire logic ackValid,
   input wire logic [31:0] ackRdata,
   input wire logic wakePin,
   input wire logic hostIrq
);
   default clocking cb @(posedge clk_sys);
   endclocking
   default disable iff (!rst_n);

   // -------------------------------------------------------------------
   // Request tracking.
   // -------------------------------------------------------------------
   logic lastWr_q;
   logic [`PMW_ADDR_W-1:0] lastAddr_q;
   logic notReady_q;
   logic woke_q;
   wire rd0Ack = ackValid && !lastWr_q && lastAddr_q == `PMW_REG_PWRCTL;
   wire probeAck = ackValid && lastWr_q && lastAddr_q == `PMW_REG_PROBE;
   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         lastWr_q <= 1'b0;
         lastAddr_q <= 4'h0;
         notReady_q <= 1'b0;
         woke_q <= 1'b0;
      end else begin
         if (reqValid) begin
            lastWr_q <= reqWrite;
            lastAddr_q <= reqAddr;
         end
         if (rd0Ack) begin
            notReady_q <= ~ackRdata[0];
         end
         if (probeAck && notReady_q) begin
            woke_q <= 1'b1;
         end else if (rd0Ack) begin
            woke_q <= 1'b0;
         end
      end
   end

   // -------------------------------------------------------------------
   // Properties.
   // -------------------------------------------------------------------
   property p_ackFollow;
      reqValid |=> ackValid ##1 !ackValid;
   endproperty
   a_ackFollow: assert property (p_ackFollow)
      else $error("ack did not follow request by one cycle");
   property p_ackOnly;
      ackValid |-> $past(reqValid);
   endproperty
   a_ackOnly: assert property (p_ackOnly)
      else $error("ack without a request");
   property p_wrZero;
      reqValid && reqWrite |=> ackRdata == 32'h0;
   endproperty
   a_wrZero: assert property (p_wrZero)
      else $error("write answered with data");
   property p_forbidRd;
      ackValid && !lastWr_q && lastAddr_q != `PMW_REG_PWRCTL && notReady_q
         |-> ackRdata == 32'h0;
   endproperty
   a_forbidRd: assert property (p_forbidRd)
      else $error("read while not ready returned data");
   property p_normSel;
      rd0Ack && ackRdata[0] |-> ackRdata[2:1] == `PMW_SEL_NORMAL;
   endproperty
   a_normSel: assert property (p_normSel)
      else $error("ready set while select not normal");
   property p_srcCode;
      rd0Ack |-> ackRdata[5:4] != 2'h3;
   endproperty
   a_srcCode: assert property (p_srcCode)
      else $error("wake source holds both codes");
   property p_selCode;
      rd0Ack |-> ackRdata[2:1] != 2'h3;
   endproperty
   a_selCode: assert property (p_selCode)
      else $error("select field holds an unused code");
   property p_probeWake;
      rd0Ack && woke_q |-> ackRdata[2:1] == `PMW_SEL_NORMAL;
   endproperty
   a_probeWake: assert property (p_probeWake)
      else $error("probe write did not reset select");

   c_wake: cover property ($rose(wakePin));
   c_irq: cover property ($rose(hostIrq));
   c_probe: cover property (probeAck && notReady_q);
endmodule

// >>> verification/power_state_wake_control_tb.sv
`timescale 1ns/1ps
`include "pmw_defs.svh"

module power_state_wake_control_tb;
   import pmw_pkg::*;
   localparam int READY_CYC = 20;
   localparam int PULSE_CYC = 30;
   localparam int LIMIT = 20000;
   localparam logic [31:0] PINEN = 32'h100;
   localparam logic [31:0] PULSE = 32'h200;
   localparam logic [31:0] WOLEN = 32'h400;
   localparam logic [31:0] EDEN = 32'h800;
   localparam logic [31:0] EDPD = 32'h2000;
   logic clk_sys;
   logic rst_n = 1'b0;
   logic hsel = 1'b0;
   logic hwrite = 1'b0;
   logic frameDetect = 1'b0;
   logic lineEnergy = 1'b0;
   logic [31:0] haddr = 32'h0;
   logic [31:0] hwdata = 32'h0;
   logic [1:0] htrans = 2'h0;
   logic [2:0] hsize = 3'h2;
   logic [31:0] hrdata;
   logic hreadyOut, hresp, clkEnMacHost, clkEnRxPm, clkEnInternal;
   logic phyEnergyPowerdown;
   int n_mismatch = 0;
   int check_count = 0;
   int cyc = 0;
   int hiRun = 0;
   int lastHi = 0;

   pmw_if link();
   pmw_device #(.READY_CYC(READY_CYC), .PULSE_CYC(PULSE_CYC))
      pmw_device_inst(.clk_sys(clk_sys), .rst_n(rst_n), .link(link),
      .frameDetect(frameDetect), .lineEnergy(lineEnergy),
      .clkEnMacHost(clkEnMacHost), .clkEnRxPm(clkEnRxPm),
      .clkEnInternal(clkEnInternal),
      .phyEnergyPowerdown(phyEnergyPowerdown));
   pmw_host pmw_host_inst(.clk_sys(clk_sys), .rst_n(rst_n), .link(link),
      .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
      .hsize(hsize), .hwdata(hwdata), .hready(hreadyOut),
      .hrdata(hrdata), .hreadyout(hreadyOut), .hresp(hresp));
   pmw_props pmw_props_inst(.clk_sys(clk_sys), .rst_n(rst_n),
      .reqValid(link.reqValid), .reqWrite(link.reqWrite),
      .reqAddr(link.reqAddr), .reqWdata(link.reqWdata),
      .ackValid(link.ackValid), .ackRdata(link.ackRdata),
      .wakePin(link.wakePin), .hostIrq(link.hostIrq));

   initial begin
      clk_sys = 1'b0;
      forever #4 clk_sys = ~clk_sys;
   end

   // Width of the most recent wake pin pulse.
   always @(posedge clk_sys) begin
      cyc <= cyc + 1;
      if (link.wakePin === 1'b1) begin
         hiRun <= hiRun + 1;
      end else begin
         if (hiRun != 0) lastHi <= hiRun;
         hiRun <= 0;
      end
      if (cyc == LIMIT) begin
         n_mismatch = n_mismatch + 1;
         tally_and_finish();
      end
   end

   task automatic tally_and_finish();
      $display("Comparisons %0d, mismatches %0d", check_count, n_mismatch);
      if (n_mismatch == 0 && check_count > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      check_count = check_count + 1;
      if (seen !== exp) begin
         n_mismatch = n_mismatch + 1;
         $display("Error at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic ahb(input logic wr, input logic [7:0] a,
                      input logic [31:0] wd, output logic [31:0] rd);
      @(posedge clk_sys);
      hsel <= 1'b1;
      haddr <= {24'h0, a};
      htrans <= 2'b10;
      hwrite <= wr;
      do @(posedge clk_sys); while (hreadyOut !== 1'b1);
      hsel <= 1'b0;
      htrans <= 2'b00;
      hwdata <= wd;
      do @(posedge clk_sys); while (hreadyOut !== 1'b1);
      rd = hrdata;
      check({31'h0, hresp}, 32'h0);
   endtask

   task automatic lnk(input logic wr, input logic [3:0] idx,
                      input logic [31:0] wd, output logic [31:0] rd);
      logic [31:0] s;
      ahb(1'b1, `PMW_H_TARGET, {23'h0, wr, 4'h0, idx}, s);
      ahb(1'b1, `PMW_H_WDATA, wd, s);
      ahb(1'b1, `PMW_H_GO, 32'h0, s);
      repeat (3) @(posedge clk_sys);
      s = 32'h1;
      while (s[`PMW_H_BUSY_BIT] !== 1'b0) ahb(1'b0, `PMW_H_STATUS, 32'h0, s);
      ahb(1'b0, `PMW_H_RDATA, 32'h0, rd);
   endtask

   task automatic wr(input logic [3:0] idx, input logic [31:0] wd);
      logic [31:0] v;
      lnk(1'b1, idx, wd, v);
   endtask

   task automatic rdchk(input logic [3:0] idx, input logic [31:0] mask,
                        input logic [31:0] exp);
      logic [31:0] v;
      lnk(1'b0, idx, 32'h0, v);
      check(v & mask, exp);
   endtask

   task automatic wait_pin(input logic lvl);
      for (int i = 0; i < 40 && link.wakePin !== lvl; i++) @(posedge clk_sys);
      check({31'h0, link.wakePin}, {31'h0, lvl});
   endtask

   task automatic wait_ready();
      logic [31:0] v;
      int t0;
      t0 = cyc;
      v = 32'h0;
      while (v[0] !== 1'b1 && cyc - t0 < 3000) lnk(1'b0, 4'h0, 32'h0, v);
      check({31'h0, (cyc - t0) <= READY_CYC + 80}, 32'h1);
   endtask

   task automatic t_first();
      logic [31:0] v;
      wr(4'h2, 32'h1);
      rdchk(4'h2, 32'hffff_ffff, 32'h0);
      rdchk(4'h0, 32'hffff_ffff, `PMW_CTRL_RESET);
      wr(4'h2, 32'h1);
      rdchk(4'h2, 32'hffff_ffff, 32'h1);
      ahb(1'b0, 8'h40, 32'h0, v);
      check(v, 32'h0);
      check({clkEnMacHost, clkEnRxPm, clkEnInternal}, 32'h7);
   endtask

   task automatic t_frame();
      logic [31:0] v;
      wr(4'h0, PINEN | WOLEN | 32'h2);
      check({clkEnMacHost, clkEnRxPm, clkEnInternal}, 32'h3);
      rdchk(4'h0, 32'h7, 32'h2);
      wr(4'h2, 32'h0);
      rdchk(4'h2, 32'hffff_ffff, 32'h0);
      frameDetect <= 1'b1;
      repeat (8) @(posedge clk_sys);
      frameDetect <= 1'b0;
      wait_pin(1'b1);
      ahb(1'b0, `PMW_H_STATUS, 32'h0, v);
      check(v & 32'h6, 32'h6);
      rdchk(4'h0, 32'h30, 32'h20);
      wr(4'h3, 32'h0000_abcd);
      wait_ready();
      rdchk(4'h0, 32'hffff_ffff, 32'h1 | PINEN | WOLEN | 32'h20);
      rdchk(4'h2, 32'hffff_ffff, 32'h1);
      wr(4'h1, 32'h1);
      rdchk(4'h1, 32'hffff_ffff, 32'h1);
      repeat (PULSE_CYC + 10) @(posedge clk_sys);
      check({31'h0, link.wakePin}, 32'h1);
      wr(4'h0, WOLEN);
      wait_pin(1'b0);
      check({31'h0, link.hostIrq}, 32'h1);
      wr(4'h0, WOLEN | 32'h20);
      rdchk(4'h0, 32'h30, 32'h0);
      wr(4'h1, 32'h1);
      rdchk(4'h1, 32'hffff_ffff, 32'h0);
      repeat (3) @(posedge clk_sys);
      check({31'h0, link.hostIrq}, 32'h0);
   endtask

   task automatic t_energy();
      lineEnergy <= 1'b1;
      repeat (8) @(posedge clk_sys);
      wr(4'h4, EDPD);
      check({31'h0, phyEnergyPowerdown}, 32'h1);
      wr(4'h0, PINEN | PULSE | EDEN | 32'h4);
      check({clkEnMacHost, clkEnRxPm, clkEnInternal}, 32'h0);
      wait_pin(1'b0);
      repeat (3) @(posedge clk_sys);
      check(32'(lastHi), 32'(PULSE_CYC));
      rdchk(4'h0, 32'h37, 32'h14);
      wr(4'h3, 32'h0);
      wait_ready();
      rdchk(4'h0, 32'h7, 32'h1);
      wr(4'h4, 32'h0);
      check({31'h0, phyEnergyPowerdown}, 32'h0);
      wr(4'h0, EDEN | 32'h10);
      rdchk(4'h0, 32'h30, 32'h0);
      lineEnergy <= 1'b0;
   endtask

   initial begin
      repeat (5) @(posedge clk_sys);
      rst_n <= 1'b1;
      t_first();
      t_frame();
      t_energy();
      tally_and_finish();
   end
endmodule
